// ==== verilog/flash_cmd_map.svh ====
// Opcodes, identification layout, field positions and timing figures for the command block
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH

`define OP_IDENT        8'h9f
`define OP_SOFT_RESET   8'hf0
`define OP_SUSPEND      8'hb0
`define OP_RESUME       8'hd0
`define RST_FILL_BYTE   8'h00
`define RST_LAST_IDX    2'h3
`define RST_FIRST_IDX   2'h1
`define EXT_LEN_VALUE   8'h01
`define RESERVED_BITS   3'h0
`define BIT_LAST        3'h7
`define BIT_FIRST       3'h0
`define ID_BITS         6'h28
`define ID_LAST         6'h27
`define ID_START        6'h00
`define CLK_PERIOD_NS   10
`define RESET_ABORT_NS  35000

`define GRP_A_OPS 8'hd2, 8'h01, 8'h03, 8'h0b, 8'h1b, 8'he8, 8'hd1, 8'hd3, 8'hd4, 8'hd6, \
  8'h32, 8'h35, 8'h77, 8'h54, 8'h56, 8'h52, 8'h68
`define GRP_B_SUSP_OPS 8'h81, 8'h50, 8'h7c, 8'hc7, 8'h83, 8'h86, 8'h88, 8'h89, 8'h82, \
  8'h85, 8'h02
`define GRP_B_FIXED_OPS 8'h53, 8'h55, 8'h60, 8'h61, 8'h58, 8'h59
`define GRP_C_OPS 8'h84, 8'h87, 8'hd7, 8'h57, 8'h9f
`define STATUS_OPS 8'hd7, 8'h57
`define GRP_D_OPS 8'h3d, 8'h9b, 8'h34

`endif

// ==== verilog/flash_cmd_pkg.sv ====
// Types shared by the serial command block
package flash_cmd_pkg;

  typedef enum logic [2:0] {
    st_opcode,
    st_ident,
    st_rst_seq,
    st_rst_armed,
    st_ignore
  } spi_state_t;

  typedef enum logic [2:0] {
    grp_read,
    grp_self_timed,
    grp_buffer_status,
    grp_config,
    grp_suspend,
    grp_reset,
    grp_other
  } cmd_group_t;

endpackage

// ==== verilog/flash_ident_reset_cmd_ctrl.sv ====
// Serial flash command block: identification read, soft reset and command overlap gating
//
// Function
// - opcode 9Fh starts identification output
// - order: maker, two device, length, extended
// - fourth identification byte equals 01h
// - output floats after extended byte
// - chip select release ends read, floats output
// - device byte one: family, density
// - device byte two: series, variant
// - extended byte: revision low, reserved zeros
// - F0h plus three zeros; extras ignored
// - release aborts program/erase within abort time
// - protection, lockdown, page size untouched
// - soft reset clears suspend flags
// - soft reset cancels active suspend
// - short or misaligned sequence does nothing
// - erase/program suspendable; reads allowed suspended
`timescale 1ns/100ps
`include "flash_cmd_map.svh"

module flash_ident_reset_cmd_ctrl
  import flash_cmd_pkg::*;
#(
  parameter logic [7:0] MFR_CODE       = 8'h5a,  // Arbitrary value
  parameter logic [2:0] FAMILY_CODE    = 3'h2,   // Arbitrary value
  parameter logic [4:0] DENSITY_CODE   = 5'h0a,  // Arbitrary value
  parameter logic [2:0] SUB_CODE       = 3'h1,   // Arbitrary value
  parameter logic [4:0] VARIANT_CODE   = 5'h03,  // Arbitrary value
  parameter logic [4:0] REVISION_CODE  = 5'h02,  // Arbitrary value
  parameter int         RESET_ABORT_NS = `RESET_ABORT_NS
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  output logic            so_out,
  output logic            so_oe,
  input  wire logic       st_busy_b,
  input  wire logic       st_busy_d,
  input  wire logic       st_suspendable,
  input  wire logic       prog_susp_set_a,
  input  wire logic       prog_susp_set_b,
  input  wire logic       erase_susp_set,
  input  wire logic       susp_clear,
  output logic            prog_suspend_flag_a,
  output logic            prog_suspend_flag_b,
  output logic            erase_suspend_flag,
  output logic            reset_abort,
  output logic            suspend_cancel,
  output logic            cmd_valid,
  output logic [7:0]      cmd_opcode,
  output cmd_group_t      cmd_group,
  output logic            cmd_allowed,
  output logic            suspend_req
);

  // Longest time rounds down, but never below one cycle
  localparam int ABORT_RAW    = RESET_ABORT_NS / `CLK_PERIOD_NS;
  localparam int ABORT_CYCLES = (ABORT_RAW < 1) ? 1 : ABORT_RAW;
  localparam int ABORT_W      = $clog2(ABORT_CYCLES + 1);

  if (RESET_ABORT_NS < 1) begin : g_abort_check
    $error("RESET_ABORT_NS must be positive");
  end

  function automatic cmd_group_t classify(input logic [7:0] op);
    cmd_group_t g;
    g = grp_other;
    case (op)
      `GRP_A_OPS:                        g = grp_read;
      `GRP_B_SUSP_OPS, `GRP_B_FIXED_OPS: g = grp_self_timed;
      `GRP_C_OPS:                        g = grp_buffer_status;
      `GRP_D_OPS:                        g = grp_config;
      `OP_SUSPEND, `OP_RESUME:           g = grp_suspend;
      `OP_SOFT_RESET:                    g = grp_reset;
      default:                           g = grp_other;
    endcase
    return g;
  endfunction

  function automatic logic is_status(input logic [7:0] op);
    logic s;
    s = 1'b0;
    case (op)
      `STATUS_OPS: s = 1'b1;
      default:     s = 1'b0;
    endcase
    return s;
  endfunction

  // Soft reset is honoured in every phase since its purpose is to abort
  function automatic logic allowed(input logic [7:0] op, input logic busy_b,
                                   input logic busy_d, input logic suspendable,
                                   input logic suspended);
    cmd_group_t g;
    logic       a;
    g = classify(op);
    a = 1'b0;
    if (g == grp_reset)
      a = 1'b1;
    else if (busy_d)
      a = is_status(op);
    else if (busy_b)
      a = (g == grp_buffer_status) || (op == `OP_SUSPEND && suspendable);
    else if (suspended)
      a = (g == grp_read) || (g == grp_buffer_status) || (op == `OP_RESUME);
    else
      a = (g != grp_suspend);
    return a;
  endfunction

  logic [39:0] id_vec;
  assign id_vec = {MFR_CODE,
                   FAMILY_CODE, DENSITY_CODE,
                   SUB_CODE, VARIANT_CODE,
                   `EXT_LEN_VALUE,
                   `RESERVED_BITS, REVISION_CODE};

  // Serial side state
  spi_state_t  state_reg, state_next;
  logic        sck_prev_reg, sck_prev_next;
  logic        cs_prev_reg, cs_prev_next;
  logic [2:0]  bit_reg, bit_next;
  logic [7:0]  shift_reg, shift_next;
  logic [1:0]  rst_idx_reg, rst_idx_next;
  logic [5:0]  id_bit_reg, id_bit_next;
  logic        so_out_reg, so_out_next;
  logic        so_oe_reg, so_oe_next;
  logic        cmd_valid_reg, cmd_valid_next;
  logic [7:0]  cmd_opcode_reg, cmd_opcode_next;
  cmd_group_t  cmd_group_reg, cmd_group_next;
  logic        cmd_allowed_reg, cmd_allowed_next;
  logic        suspend_req_reg, suspend_req_next;
  logic        rst_fire;

  // Suspend and abort state
  logic               psa_reg, psa_next;
  logic               psb_reg, psb_next;
  logic               erase_sus_reg, erase_sus_next;
  logic               abort_reg, abort_next;
  logic [ABORT_W-1:0] abort_cnt_reg, abort_cnt_next;
  logic               cancel_reg, cancel_next;

  logic rise, fall, cs_release, suspended;
  logic [7:0] byte_in;

  assign rise       = !cs_n && sck && !sck_prev_reg;
  assign fall       = !cs_n && !sck && sck_prev_reg;
  assign cs_release = cs_n && !cs_prev_reg;
  assign suspended  = psa_reg || psb_reg || erase_sus_reg;
  assign byte_in    = {shift_reg[6:0], si};

  always_comb begin
    state_next       = state_reg;
    sck_prev_next    = sck;
    cs_prev_next     = cs_n;
    bit_next         = bit_reg;
    shift_next       = shift_reg;
    rst_idx_next     = rst_idx_reg;
    id_bit_next      = id_bit_reg;
    so_out_next      = so_out_reg;
    so_oe_next       = so_oe_reg;
    cmd_valid_next   = 1'b0;
    cmd_opcode_next  = cmd_opcode_reg;
    cmd_group_next   = cmd_group_reg;
    cmd_allowed_next = cmd_allowed_reg;
    suspend_req_next = 1'b0;
    rst_fire         = 1'b0;
    if (cs_n) begin
      // Release at any bit count ends the frame and floats the output
      state_next  = st_opcode;
      so_oe_next  = 1'b0;
      bit_next    = `BIT_FIRST;
      id_bit_next = `ID_START;
      if (cs_release && state_reg == st_rst_armed && bit_reg == `BIT_FIRST)
        rst_fire = 1'b1;
    end else begin
      if (rise) begin
        shift_next = byte_in;
        bit_next   = bit_reg + 3'h1;
        if (bit_reg == `BIT_LAST) begin
          unique case (state_reg)
            st_opcode: begin
              cmd_valid_next   = 1'b1;
              cmd_opcode_next  = byte_in;
              cmd_group_next   = classify(byte_in);
              cmd_allowed_next = allowed(byte_in, st_busy_b, st_busy_d,
                                         st_suspendable, suspended);
              if (byte_in == `OP_SUSPEND && st_busy_b && st_suspendable && !st_busy_d)
                suspend_req_next = 1'b1;
              if (byte_in == `OP_IDENT)
                state_next = st_ident;
              else if (byte_in == `OP_SOFT_RESET) begin
                state_next   = st_rst_seq;
                rst_idx_next = `RST_FIRST_IDX;
              end else
                state_next = st_ignore;
            end
            st_rst_seq: begin
              if (byte_in != `RST_FILL_BYTE)
                state_next = st_ignore;
              else if (rst_idx_reg == `RST_LAST_IDX)
                state_next = st_rst_armed;
              else
                rst_idx_next = rst_idx_reg + 2'h1;
            end
            // Bytes after the fourth reset byte change nothing
            st_rst_armed: state_next = st_rst_armed;
            st_ident:     state_next = st_ident;
            st_ignore:    state_next = st_ignore;
          endcase
        end
      end
      // Data launches on the falling edge so the host samples it on the rising one
      if (fall && state_reg == st_ident) begin
        if (id_bit_reg != `ID_BITS) begin
          so_out_next = id_vec[`ID_LAST - id_bit_reg];
          so_oe_next  = 1'b1;
          id_bit_next = id_bit_reg + 6'h01;
        end else
          so_oe_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg       <= st_opcode;
      sck_prev_reg    <= 1'b0;
      cs_prev_reg     <= 1'b1;
      bit_reg         <= `BIT_FIRST;
      shift_reg       <= 8'h00;
      rst_idx_reg     <= 2'h0;
      id_bit_reg      <= `ID_START;
      so_out_reg      <= 1'b0;
      so_oe_reg       <= 1'b0;
      cmd_valid_reg   <= 1'b0;
      cmd_opcode_reg  <= 8'h00;
      cmd_group_reg   <= grp_other;
      cmd_allowed_reg <= 1'b0;
      suspend_req_reg <= 1'b0;
    end else begin
      state_reg       <= state_next;
      sck_prev_reg    <= sck_prev_next;
      cs_prev_reg     <= cs_prev_next;
      bit_reg         <= bit_next;
      shift_reg       <= shift_next;
      rst_idx_reg     <= rst_idx_next;
      id_bit_reg      <= id_bit_next;
      so_out_reg      <= so_out_next;
      so_oe_reg       <= so_oe_next;
      cmd_valid_reg   <= cmd_valid_next;
      cmd_opcode_reg  <= cmd_opcode_next;
      cmd_group_reg   <= cmd_group_next;
      cmd_allowed_reg <= cmd_allowed_next;
      suspend_req_reg <= suspend_req_next;
    end
  end

  // Protection, lockdown and page size live elsewhere and are never touched here
  always_comb begin
    psa_next       = psa_reg;
    psb_next       = psb_reg;
    erase_sus_next = erase_sus_reg;
    abort_next     = abort_reg;
    abort_cnt_next = abort_cnt_reg;
    cancel_next    = 1'b0;
    if (abort_reg) begin
      if (abort_cnt_reg == '0)
        abort_next = 1'b0;
      else
        abort_cnt_next = abort_cnt_reg - ABORT_W'(1);
    end
    if (susp_clear || rst_fire) begin
      psa_next = 1'b0;
      psb_next = 1'b0;
      erase_sus_next = 1'b0;
    end
    if (rst_fire) begin
      abort_next     = 1'b1;
      abort_cnt_next = ABORT_W'(ABORT_CYCLES - 1);
      cancel_next    = suspended;
    end
    // A new suspend event wins over a clear in the same cycle
    if (prog_susp_set_a)
      psa_next = 1'b1;
    if (prog_susp_set_b)
      psb_next = 1'b1;
    if (erase_susp_set)
      erase_sus_next = 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      psa_reg       <= 1'b0;
      psb_reg       <= 1'b0;
      erase_sus_reg <= 1'b0;
      abort_reg     <= 1'b0;
      abort_cnt_reg <= '0;
      cancel_reg    <= 1'b0;
    end else begin
      psa_reg       <= psa_next;
      psb_reg       <= psb_next;
      erase_sus_reg <= erase_sus_next;
      abort_reg     <= abort_next;
      abort_cnt_reg <= abort_cnt_next;
      cancel_reg    <= cancel_next;
    end
  end

  assign so_out              = so_out_reg;
  assign so_oe               = so_oe_reg;
  assign prog_suspend_flag_a = psa_reg;
  assign prog_suspend_flag_b = psb_reg;
  assign erase_suspend_flag  = erase_sus_reg;
  assign reset_abort         = abort_reg;
  assign suspend_cancel      = cancel_reg;
  assign cmd_valid           = cmd_valid_reg;
  assign cmd_opcode          = cmd_opcode_reg;
  assign cmd_group           = cmd_group_reg;
  assign cmd_allowed         = cmd_allowed_reg;
  assign suspend_req         = suspend_req_reg;

endmodule

// ==== test/flash_cmd_ctrl_properties.sv ====
// Concurrent checks on the serial command block ports
`timescale 1ns/100ps
module flash_cmd_ctrl_checker #(
  parameter int RESET_ABORT_NS = 500
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       cs_n,
  input wire logic       so_oe,
  input wire logic       st_busy_b,
  input wire logic       st_busy_d,
  input wire logic       st_suspendable,
  input wire logic       erase_susp_set,
  input wire logic       erase_suspend_flag,
  input wire logic       reset_abort,
  input wire logic       suspend_cancel,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic       cmd_allowed,
  input wire logic       suspend_req
);
  // Abort window is whole clock periods, never shorter than one cycle
  localparam int ABORT_CYCLES = (RESET_ABORT_NS / 10 < 1) ? 1 : RESET_ABORT_NS / 10;
  int cnt_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Length of the abort window is too long for a repetition, so it is counted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_reg <= 0;
    else cnt_reg <= reset_abort ? cnt_reg + 1 : 0;
  end
  property p_oe_off_cs; cs_n |=> !so_oe; endproperty
  a_oe_off_cs: assert property (p_oe_off_cs) else $error("SO driven after deselect");
  property p_oe_ident; $rose(so_oe) |-> cmd_opcode == 8'h9f; endproperty
  a_oe_ident: assert property (p_oe_ident) else $error("SO driven without ident");
  property p_susp_req; suspend_req |-> cmd_valid && cmd_opcode == 8'hb0 && cmd_allowed; endproperty
  a_susp_req: assert property (p_susp_req) else $error("Stray suspend request");
  property p_susp_fire;
    cmd_valid && cmd_opcode == 8'hb0 && st_busy_b && st_suspendable && !st_busy_d |-> suspend_req;
  endproperty
  a_susp_fire: assert property (p_susp_fire) else $error("Suspend request missing");
  property p_flags_clr;
    $rose(reset_abort) && !$past(erase_susp_set) |-> !erase_suspend_flag;
  endproperty
  a_flags_clr: assert property (p_flags_clr) else $error("Erase flag kept over reset");
  property p_cancel; suspend_cancel |-> $rose(reset_abort); endproperty
  a_cancel: assert property (p_cancel) else $error("Cancel without reset");
  property p_abort_len; $fell(reset_abort) |-> cnt_reg == ABORT_CYCLES; endproperty
  a_abort_len: assert property (p_abort_len) else $error("Abort window length wrong");
  property p_busy_d;
    cmd_valid && st_busy_d && $stable(st_busy_d)
      |-> cmd_allowed == (cmd_opcode inside {8'hd7, 8'h57, 8'hf0});
  endproperty
  a_busy_d: assert property (p_busy_d) else $error("Gating wrong in config phase");
  property p_busy_b;
    cmd_valid && st_busy_b && !st_busy_d && $stable(st_busy_b) && $stable(st_busy_d)
      && $stable(st_suspendable) |-> cmd_allowed == ((cmd_opcode == 8'hb0 && st_suspendable)
      || cmd_opcode inside {8'h84, 8'h87, 8'hd7, 8'h57, 8'h9f, 8'hf0});
  endproperty
  a_busy_b: assert property (p_busy_b) else $error("Gating wrong in self-timed phase");
  c_abort: cover property ($rose(reset_abort));
  c_susp: cover property (suspend_req);
  c_ident: cover property ($rose(so_oe));
endmodule

bind flash_ident_reset_cmd_ctrl flash_cmd_ctrl_checker #(.RESET_ABORT_NS(RESET_ABORT_NS)) u_chk (
  .clk, .rst, .cs_n, .so_oe, .st_busy_b, .st_busy_d, .st_suspendable, .erase_susp_set,
  .erase_suspend_flag, .reset_abort, .suspend_cancel, .cmd_valid, .cmd_opcode, .cmd_allowed,
  .suspend_req
);

// ==== test/spi_host_model.sv ====
// Behavioural SPI host, mode 0, framing bytes towards the command block
`timescale 1ns/100ps
module spi_host_model (
  input wire logic clk,
  input wire logic so_out,
  input wire logic so_oe,
  output logic     cs_n,
  output logic     sck,
  output logic     si
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // Two clk per half period keeps sck far below any identification rating
  // No buffer data is ever sent, so no write can share a busy buffer
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx,
                      output logic oe_all, output logic oe_any);
    rx = 8'h00;
    oe_all = 1'b1;
    oe_any = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si <= tx[7 - i];
      repeat (2) @(posedge clk);
      sck <= 1'b1;
      // A floating output reads as the inverse of its last level, so stale data shows
      rx[7 - i] = so_oe ? so_out : ~so_out;
      oe_all &= so_oe;
      oe_any |= so_oe;
      repeat (2) @(posedge clk);
      sck <= 1'b0;
    end
  endtask
  task automatic open_frame();
    @(posedge clk);
    cs_n <= 1'b0;
  endtask
  // One command per frame, with a gap before the next one
  task automatic close_frame();
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the serial command block
`timescale 1ns/100ps
module testbench;
  import flash_cmd_pkg::*;
  localparam int         ABORT_NS = 500;
  localparam logic [7:0] MFR      = 8'h3c;  // Identity values are arbitrary
  localparam logic [2:0] FAM      = 3'h5;
  localparam logic [4:0] DEN      = 5'h11;
  localparam logic [2:0] SUB      = 3'h6;
  localparam logic [4:0] VARC     = 5'h1e;
  localparam logic [4:0] REV      = 5'h1b;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cs_n, sck, si, so_out, so_oe, reset_abort, suspend_cancel, cmd_valid;
  logic        st_busy_b, st_busy_d, st_suspendable, cmd_allowed, suspend_req, oe_all, oe_any;
  logic        prog_susp_set_a, prog_susp_set_b, erase_susp_set, susp_clear;
  logic        prog_suspend_flag_a, prog_suspend_flag_b, erase_suspend_flag;
  logic [2:0]  cmd_group;
  logic [7:0]  cmd_opcode, rx;
  logic [31:0] seed = 32'h88f5;
  logic [7:0]  id_q[$];
  int          n_abort = 0, n_cancel = 0, n_susp = 0;
  int          failures = 0;
  int          n_compared = 0;
  wire  [7:0]  flags = {5'h0, prog_suspend_flag_a, prog_suspend_flag_b, erase_suspend_flag};

  flash_ident_reset_cmd_ctrl #(
    .MFR_CODE(MFR), .FAMILY_CODE(FAM), .DENSITY_CODE(DEN), .SUB_CODE(SUB),
    .VARIANT_CODE(VARC), .REVISION_CODE(REV), .RESET_ABORT_NS(ABORT_NS)
  ) uut (
    .clk, .rst, .cs_n, .sck, .si, .so_out, .so_oe, .st_busy_b, .st_busy_d, .st_suspendable,
    .prog_susp_set_a, .prog_susp_set_b, .erase_susp_set, .susp_clear, .prog_suspend_flag_a,
    .prog_suspend_flag_b, .erase_suspend_flag, .reset_abort, .suspend_cancel, .cmd_valid,
    .cmd_opcode, .cmd_group, .cmd_allowed, .suspend_req
  );
  spi_host_model host (.clk, .so_out, .so_oe, .cs_n, .sck, .si);

  always #5 clk = ~clk;
  // Pulse counters update on the edge, so reads between edges never race them
  always @(posedge clk) begin
    if (reset_abort === 1'b1) n_abort <= n_abort + 1;
    if (suspend_cancel === 1'b1) n_cancel <= n_cancel + 1;
    if (suspend_req === 1'b1) n_susp <= n_susp + 1;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Reset always passes; config phases admit status reads only
  function automatic logic [2:0] group_model(input logic [7:0] op);
    if (op inside {8'hd2, 8'h01, 8'h03, 8'h0b, 8'h1b, 8'he8, 8'hd1, 8'hd3, 8'hd4, 8'hd6,
                   8'h32, 8'h35, 8'h77, 8'h54, 8'h56, 8'h52, 8'h68}) return grp_read;
    if (op inside {8'h81, 8'h50, 8'h7c, 8'hc7, 8'h83, 8'h86, 8'h88, 8'h89, 8'h82, 8'h85,
                   8'h02, 8'h53, 8'h55, 8'h60, 8'h61, 8'h58, 8'h59}) return grp_self_timed;
    if (op inside {8'h84, 8'h87, 8'hd7, 8'h57, 8'h9f}) return grp_buffer_status;
    if (op inside {8'h3d, 8'h9b, 8'h34}) return grp_config;
    if (op inside {8'hb0, 8'hd0}) return grp_suspend;
    if (op == 8'hf0) return grp_reset;
    return grp_other;
  endfunction
  // While suspended, reads, buffer/status commands and resume pass
  function automatic logic allow_model(input logic [7:0] op, input logic b, d, s, p);
    logic [2:0] g;
    g = group_model(op);
    if (op == 8'hf0) return 1'b1;
    if (d) return op inside {8'hd7, 8'h57};
    if (b) return g == grp_buffer_status || (op == 8'hb0 && s);
    if (p) return g inside {grp_read, grp_buffer_status} || op == 8'hd0;
    return !(op inside {8'hb0, 8'hd0});
  endfunction
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    {prog_susp_set_a, prog_susp_set_b, erase_susp_set, susp_clear} <= m;
    @(posedge clk);
    {prog_susp_set_a, prog_susp_set_b, erase_susp_set, susp_clear} <= 4'h0;
    @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    give_verdict();
  end

  initial begin
    int k, n, a0;
    logic [10:0] v;
    logic        exp_ok;
    {st_busy_b, st_busy_d, st_suspendable} = 3'h0;
    {prog_susp_set_a, prog_susp_set_b, erase_susp_set, susp_clear} = 4'h0;
    id_q = '{MFR, {FAM, DEN}, {SUB, VARC}, 8'h01, {3'h0, REV}};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    host.open_frame();
    host.xfer(8'h9f, 8, rx, oe_all, oe_any);
    for (k = 0; k < 6; k++) begin
      host.xfer(8'h00, 8, rx, oe_all, oe_any);
      if (k < 5) check_byte("id byte", id_q[k], rx);
      check_bit("id drive", k < 5, k < 5 ? oe_all : oe_any);
    end
    host.close_frame();
    // Host walks away in mid-byte of the maker code
    seed = xs(seed);
    n = 1 + seed[2:0] % 7;
    host.open_frame();
    host.xfer(8'h9f, 8, rx, oe_all, oe_any);
    host.xfer(8'h00, n, rx, oe_all, oe_any);
    host.close_frame();
    check_byte("partial id", id_q[0] & ~(8'hff >> n), rx);
    check_bit("drive after deselect", 1'b0, so_oe);
    pulse(4'h8);
    pulse(4'h1);
    pulse(4'he);
    check_byte("flags set", 8'h07, flags);
    a0 = n_abort;
    n = n_cancel;
    seed = xs(seed);
    host.open_frame();
    for (k = 0; k < 5; k++) begin
      host.xfer(k == 0 ? 8'hf0 : (k == 4 ? seed[7:0] : 8'h00), 8, rx, oe_all, oe_any);
    end
    host.close_frame();
    check_bit("abort", 1'b1, reset_abort);
    check_byte("flags reset", 8'h00, flags);
    repeat (60) @(posedge clk);
    check_byte("abort cycles", 8'(ABORT_NS / 10), 8'(n_abort - a0));
    check_byte("cancel pulses", 8'h01, 8'(n_cancel - n));
    // Short, misaligned and corrupted sequences
    for (k = 0; k < 3; k++) begin
      a0 = n_abort;
      seed = xs(seed);
      host.open_frame();
      host.xfer(8'hf0, 8, rx, oe_all, oe_any);
      host.xfer(8'h00, 8, rx, oe_all, oe_any);
      host.xfer(k == 2 ? seed[7:0] | 8'h01 : 8'h00, 8, rx, oe_all, oe_any);
      if (k != 0) host.xfer(8'h00, 8, rx, oe_all, oe_any);
      if (k == 1) host.xfer(8'h00, 3, rx, oe_all, oe_any);
      host.close_frame();
      check_byte("refused reset", 8'h00, 8'(n_abort - a0));
    end
    for (k = 0; k < 16; k++) begin
      // From here on an erase stays suspended, so the suspended gating is exercised
      if (k == 6) pulse(4'h2);
      seed = xs(seed);
      v = k == 0 ? {8'hb0, 3'b101} : (k == 1 ? {8'hd7, 3'b010} : seed[10:0]);
      {st_busy_b, st_busy_d, st_suspendable} <= v[2:0];
      n = n_susp;
      host.open_frame();
      host.xfer(v[10:3], 8, rx, oe_all, oe_any);
      host.close_frame();
      check_byte("opcode", v[10:3], cmd_opcode);
      exp_ok = allow_model(v[10:3], v[2], v[1], v[0], k >= 6);
      check_bit("allowed", exp_ok, cmd_allowed);
      check_byte("group", {5'h0, group_model(v[10:3])}, {5'h0, cmd_group});
      check_byte("suspend requests", 8'(v == {8'hb0, 3'b101}), 8'(n_susp - n));
    end
    give_verdict();
  end
endmodule
